// >>> hw/edc_pkg.sv
// Notes on behaviour
// [RULE_01] After power-up wait at least 200 us, then eight row-strobe cycles before access.
// [RULE_02] Relying on the internal counter, warm up with eight column-first refresh cycles.
// [RULE_03] Strobes idle over 8 ms need eight fresh initialization cycles before access.
// [RULE_04] Write strobe low early around column strobe fall gives early write, outputs off.
// [RULE_05] Write strobe falling late enough gives read-write; old data shown first.
// [RULE_06] Write strobe timing meeting neither case leaves outputs undefined; never rely on it.
// [RULE_07] Write data taken at column strobe fall (early write) or write strobe fall.
// [RULE_08] A read ends with write strobe high past column or row strobe rise.
// [RULE_09] Outputs open within 13/15 ns of the later rising row or column strobe.
// [RULE_10] Read data valid after the longest of address, column and precharge access.
// [RULE_11] Late column strobe or address makes access depend on that delay alone.
// [RULE_12] Page mode row strobe low up to 100K ns; column cycles at least 20/25 ns.
// [RULE_13] A read-modify-write page column cycle lasts at least 47/56 ns.
// [RULE_14] In page reads previous data holds 5 ns after next column strobe fall.
// [RULE_15] Outputs turn off 13/15 ns after row, write strobe or output gate release.
// [RULE_16] Column-first refresh: column strobe low 5 ns before row strobe, held 8/10 ns.
// [RULE_17] Self-refresh holds row strobe low 100 us; on exit high at least 90/105 ns.
// [RULE_18] In the refresh counter test, column strobe stays high 10 ns between pulses.
// [RULE_19] Row strobe stays low 30/35 ns after the last column precharge begins.
// [RULE_20] All 4096 rows are refreshed within every 64 ms.
// [RULE_21] Column-first refresh uses the internal row counter, outputs stay high impedance.
// [RULE_22] Hidden refresh refreshes an internal row and keeps driving the previous data.
// [RULE_23] Refresh requests win over host accesses so long page bursts miss no deadline.
package edc_pkg;

	localparam int CLK_NS = 20;
	localparam int CNT_W = 16;

	localparam int T_PWRUP_NS = 200000;
	localparam int PWRUP_CYC = (T_PWRUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int INIT_CYCLES = 8;

	localparam int T_REF_NS = 64000000;
	localparam int REF_ROWS = 4096;
	localparam int REF_INT_CYC = T_REF_NS / REF_ROWS / CLK_NS;
	localparam int T_IDLE_NS = 8000000;
	localparam int IDLE_CYC = T_IDLE_NS / CLK_NS;

	localparam int T_RP_NS = 40;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RAS_NS = 60;
	localparam int RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RAH_NS = 10;
	localparam int RAH_CYC = (T_RAH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_CSR_NS = 5;
	localparam int CSR_CYC = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ACC_NS = 35;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_CAS_NS = 10;
	localparam int CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RASP_NS = 100000;
	localparam int RASP_CYC = T_RASP_NS / CLK_NS;
	localparam int PAGE_GUARD = 16;
	localparam int T_RASS_NS = 100000;
	localparam int RASS_CYC = (T_RASS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RPS_NS = 105;
	localparam int RPS_CYC = (T_RPS_NS + CLK_NS - 1) / CLK_NS;

	typedef enum {
		ST_PWRUP,
		ST_CBR_SET,
		ST_CBR_LOW,
		ST_SR_EXIT,
		ST_PRE,
		ST_IDLE,
		ST_ROW,
		ST_WSET,
		ST_COL,
		ST_CAS_HI,
		ST_RAS_HOLD
	} edc_state_e;

endpackage : edc_pkg

// >>> hw/edc_tick.sv
`timescale 1ns/1ns
module edc_tick import edc_pkg::*; #(
	parameter int PERIOD = REF_INT_CYC
) (
	input wire logic clk_sys, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic en, // Count only while high.
	output logic tick // One-cycle pulse every PERIOD enabled cycles.
);

	logic [CNT_W-1:0] cnt_reg;
	logic tick_reg;
	wire wrap = (cnt_reg == CNT_W'(PERIOD - 1));

	if (PERIOD < 2 || PERIOD >= (1 << CNT_W)) begin : g_chk
		$error("edc_tick: PERIOD out of range");
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= en && wrap;
			if (en) begin
				cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
			end
		end
	end

	assign tick = tick_reg;

endmodule : edc_tick

// >>> hw/edc_ctrl.sv
`timescale 1ns/1ns
module edc_ctrl import edc_pkg::*; #(
	parameter int ROW_W = 12,
	parameter int COL_W = 10,
	parameter int DQ_W = 4,
	parameter int PWRUP_CYCLES = PWRUP_CYC,
	parameter int RASP_CYCLES = RASP_CYC,
	parameter int RASS_CYCLES = RASS_CYC,
	parameter int REF_INTERVAL = REF_INT_CYC
) (
	input wire logic clk_sys, // System clock, 50 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic req_valid, // Access request, held until req_ack.
	input wire logic req_write, // High for write, low for read.
	input wire logic [ROW_W+COL_W-1:0] req_addr, // Row in upper bits, column in lower.
	input wire logic [DQ_W-1:0] req_wdata, // Write data.
	input wire logic sleep_req, // Level: enter and stay in self-refresh.
	output logic req_ack, // One-cycle pulse: request taken.
	output logic rsp_valid, // One-cycle pulse: read data ready.
	output logic [DQ_W-1:0] rsp_rdata, // Read data.
	output logic init_done, // Warm-up finished.
	output logic sleeping, // Self-refresh sequence in progress.
	output logic dram_ras_n, // Row strobe, active low.
	output logic dram_cas_n, // Column strobe, active low.
	output logic dram_we_n, // Write strobe, active low.
	output logic dram_oe_n, // Output gate, active low.
	output logic [ROW_W-1:0] dram_addr, // Multiplexed address.
	input wire logic [DQ_W-1:0] dram_dq_in, // Data pins, input side.
	output logic [DQ_W-1:0] dram_dq_out, // Data pins, output side.
	output logic dram_dq_oe // High while this end drives the data pins.
);

	if (ROW_W < COL_W || DQ_W < 1) begin : g_chk_w
		$error("edc_ctrl: address or data width unusable");
	end
	if (PWRUP_CYCLES < 2 || PWRUP_CYCLES >= (1 << CNT_W) || RASS_CYCLES >= (1 << CNT_W)) begin : g_chk_t
		$error("edc_ctrl: wait count does not fit the counter");
	end
	if (RASP_CYCLES <= 2 * PAGE_GUARD || RASP_CYCLES >= (1 << CNT_W)) begin : g_chk_p
		$error("edc_ctrl: page limit unusable");
	end
	if (REF_INTERVAL >= IDLE_CYC) begin : g_chk_r
		$error("edc_ctrl: refresh interval longer than the idle limit");
	end

	edc_state_e state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next, ras_low_reg;
	logic ras_n_reg, ras_n_next, cas_n_reg, cas_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
	logic [ROW_W-1:0] addr_reg, addr_next, row_reg, row_next;
	logic [DQ_W-1:0] dq_out_reg, dq_out_next, dq_s1_reg, dq_s2_reg, rsp_rdata_reg;
	logic dq_oe_reg, dq_oe_next, wr_reg, wr_next, ack_reg, ack_next;
	logic [3:0] init_cnt_reg, init_cnt_next;
	logic init_done_reg, init_done_next, sr_reg, sr_next, ref_pend_reg, ref_start, rd_start;
	logic rd_p0_reg, rd_p1_reg, rsp_valid_reg;
	logic ref_tick;

	wire cnt_done = (cnt_reg == '0);
	wire [ROW_W-1:0] req_row = req_addr[ROW_W+COL_W-1:COL_W];
	wire [ROW_W-1:0] req_col = ROW_W'(req_addr[COL_W-1:0]);
	wire page_ok = (ras_low_reg < CNT_W'(RASP_CYCLES - PAGE_GUARD)); // RULE_12
	// Refresh or sleep closes the page at the next column boundary. RULE_23
	wire page_hit = req_valid && !ack_reg && !ref_pend_reg && !sleep_req && page_ok && (req_row == row_reg);

	// Refresh pacing keeps the strobes from ever idling for the long limit. RULE_03 RULE_20
	edc_tick #(.PERIOD(REF_INTERVAL)) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.en(init_done_reg),
		.tick(ref_tick)
	);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_done ? cnt_reg : cnt_reg - 1'b1;
		ras_n_next = ras_n_reg;
		cas_n_next = cas_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		addr_next = addr_reg;
		row_next = row_reg;
		dq_out_next = dq_out_reg;
		dq_oe_next = dq_oe_reg;
		wr_next = wr_reg;
		ack_next = 1'b0;
		init_cnt_next = init_cnt_reg;
		init_done_next = init_done_reg;
		sr_next = sr_reg;
		ref_start = 1'b0;
		rd_start = 1'b0;
		case (state_reg)
			ST_PWRUP: begin
				if (cnt_done) begin // RULE_01
					state_next = ST_CBR_SET;
					cas_n_next = 1'b0;
					cnt_next = CNT_W'(CSR_CYC - 1);
				end
			end
			ST_CBR_SET: begin
				// The column strobe stays low through the whole refresh, so the counter test never starts.
				if (cnt_done) begin // RULE_16 RULE_18
					state_next = ST_CBR_LOW;
					ras_n_next = 1'b0;
					ref_start = 1'b1;
					cnt_next = sr_reg ? CNT_W'(RASS_CYCLES - 1) : CNT_W'(RAS_CYC - 1);
				end
			end
			ST_CBR_LOW: begin
				// The self-refresh row strobe stays low at least its minimum and while sleep is asked.
				if (cnt_done && !(sr_reg && sleep_req)) begin // RULE_17
					ras_n_next = 1'b1;
					if (sr_reg) begin
						state_next = ST_SR_EXIT;
						cnt_next = CNT_W'(RPS_CYC - 1);
					end else begin
						state_next = ST_PRE;
						cas_n_next = 1'b1;
						cnt_next = CNT_W'(RP_CYC - 1);
					end
				end
			end
			ST_SR_EXIT: begin
				// Column strobe rises one cycle after the row strobe to cover its hold.
				cas_n_next = 1'b1;
				if (cnt_done) begin // RULE_17
					state_next = ST_IDLE;
					sr_next = 1'b0;
				end
			end
			ST_PRE: begin
				if (cnt_done) begin
					state_next = ST_IDLE;
					if (!init_done_reg) begin // RULE_02
						if (init_cnt_reg == 4'(INIT_CYCLES - 1)) begin
							init_done_next = 1'b1;
						end else begin
							init_cnt_next = init_cnt_reg + 1'b1;
							state_next = ST_CBR_SET;
							cas_n_next = 1'b0;
							cnt_next = CNT_W'(CSR_CYC - 1);
						end
					end
				end
			end
			ST_IDLE: begin
				if (ref_pend_reg || sleep_req) begin // RULE_23
					state_next = ST_CBR_SET;
					cas_n_next = 1'b0;
					sr_next = !ref_pend_reg;
					cnt_next = CNT_W'(CSR_CYC - 1);
				end else if (req_valid && !ack_reg) begin
					state_next = ST_ROW;
					ras_n_next = 1'b0;
					addr_next = req_row;
					row_next = req_row;
					wr_next = req_write;
					dq_out_next = req_wdata;
					ack_next = 1'b1;
					cnt_next = CNT_W'(RAH_CYC - 1);
				end
			end
			ST_ROW: begin
				if (cnt_done) begin
					addr_next = req_col;
					// Writes are always early writes, so no read-modify-write page cycle is ever issued.
					if (wr_reg) begin // RULE_04 RULE_06 RULE_13
						state_next = ST_WSET;
						we_n_next = 1'b0;
						dq_oe_next = 1'b1;
					end else begin
						state_next = ST_COL;
						cas_n_next = 1'b0;
						oe_n_next = 1'b0;
						cnt_next = CNT_W'(ACC_CYC - 1);
					end
				end
			end
			ST_WSET: begin
				// Data and write strobe settle before the column strobe falls. RULE_07
				state_next = ST_COL;
				cas_n_next = 1'b0;
				cnt_next = CNT_W'(CAS_CYC - 1);
			end
			ST_COL: begin
				if (cnt_done) begin // RULE_08 RULE_10 RULE_11
					state_next = ST_CAS_HI;
					cas_n_next = 1'b1;
					we_n_next = 1'b1;
					oe_n_next = 1'b1;
					dq_oe_next = 1'b0;
					rd_start = !wr_reg;
				end
			end
			ST_CAS_HI: begin
				// The output gate rose on entry, so a page write drives data one cycle later. RULE_15
				if (page_hit) begin // RULE_12
					addr_next = req_col;
					wr_next = req_write;
					dq_out_next = req_wdata;
					ack_next = 1'b1;
					if (req_write) begin
						state_next = ST_WSET;
						we_n_next = 1'b0;
						dq_oe_next = 1'b1;
					end else begin
						state_next = ST_COL;
						cas_n_next = 1'b0;
						oe_n_next = 1'b0;
						cnt_next = CNT_W'(ACC_CYC - 1);
					end
				end else begin
					state_next = ST_RAS_HOLD; // RULE_19
				end
			end
			ST_RAS_HOLD: begin
				state_next = ST_PRE;
				ras_n_next = 1'b1;
				cnt_next = CNT_W'(RP_CYC - 1);
			end
			default: begin
				state_next = ST_PRE;
				ras_n_next = 1'b1;
				cas_n_next = 1'b1;
				we_n_next = 1'b1;
				oe_n_next = 1'b1;
				dq_oe_next = 1'b0;
				cnt_next = CNT_W'(RP_CYC - 1);
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= ST_PWRUP;
			cnt_reg <= CNT_W'(PWRUP_CYCLES - 1);
			{ras_n_reg, cas_n_reg, we_n_reg, oe_n_reg} <= 4'hf;
			{addr_reg, row_reg} <= '0;
			{dq_out_reg, dq_oe_reg, wr_reg, ack_reg} <= '0;
			{init_cnt_reg, init_done_reg, sr_reg} <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			{ras_n_reg, cas_n_reg, we_n_reg, oe_n_reg} <= {ras_n_next, cas_n_next, we_n_next, oe_n_next};
			{addr_reg, row_reg} <= {addr_next, row_next};
			{dq_out_reg, dq_oe_reg, wr_reg, ack_reg} <= {dq_out_next, dq_oe_next, wr_next, ack_next};
			{init_cnt_reg, init_done_reg, sr_reg} <= {init_cnt_next, init_done_next, sr_next};
		end
	end

	// A tick landing in the cycle a refresh starts is kept: the set wins. RULE_20
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ref_pend_reg <= 1'b0;
			ras_low_reg <= '0;
		end else begin
			ref_pend_reg <= ref_tick || (ref_pend_reg && !ref_start);
			ras_low_reg <= ras_n_reg ? '0 : (&ras_low_reg ? ras_low_reg : ras_low_reg + 1'b1);
		end
	end

	// Pins are sampled through two flops, so the answer trails the strobe rise by two cycles.
	// Extended data out keeps the pins valid while the row strobe is still low. RULE_14
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{dq_s1_reg, dq_s2_reg, rsp_rdata_reg} <= '0;
			{rd_p0_reg, rd_p1_reg, rsp_valid_reg} <= 3'h0;
		end else begin
			dq_s1_reg <= dram_dq_in;
			dq_s2_reg <= dq_s1_reg;
			{rd_p0_reg, rd_p1_reg, rsp_valid_reg} <= {rd_start, rd_p0_reg, rd_p1_reg};
			if (rd_p1_reg) begin
				rsp_rdata_reg <= dq_s2_reg;
			end
		end
	end

	assign req_ack = ack_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_rdata = rsp_rdata_reg;
	assign init_done = init_done_reg;
	assign sleeping = sr_reg;
	assign dram_ras_n = ras_n_reg;
	assign dram_cas_n = cas_n_reg;
	assign dram_we_n = we_n_reg;
	assign dram_oe_n = oe_n_reg;
	assign dram_addr = addr_reg;
	assign dram_dq_out = dq_out_reg;
	assign dram_dq_oe = dq_oe_reg;

	// Helper counters read only by the checks below.
	logic [3:0] cbr_seen_reg;
	logic [CNT_W-1:0] since_ref_reg;
	wire cbr_fall = ref_start;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cbr_seen_reg <= '0;
			since_ref_reg <= '0;
		end else begin
			if (cbr_fall && !(&cbr_seen_reg)) begin
				cbr_seen_reg <= cbr_seen_reg + 1'b1;
			end
			since_ref_reg <= (cbr_fall || !init_done_reg || sr_reg) ? '0 :
				(&since_ref_reg ? since_ref_reg : since_ref_reg + 1'b1);
		end
	end

	property p_pwrup_quiet;
		@(posedge clk_sys) disable iff (rst) (state_reg == ST_PWRUP) |-> (ras_n_reg && cas_n_reg);
	endproperty
	a_pwrup_quiet: assert property (p_pwrup_quiet) else $error("strobe moved during power-up wait"); // RULE_01

	property p_init_count;
		@(posedge clk_sys) disable iff (rst) $rose(init_done_reg) |-> (cbr_seen_reg == 4'h8);
	endproperty
	a_init_count: assert property (p_init_count) else $error("warm-up did not use eight refresh cycles"); // RULE_02

	property p_cbr_order;
		@(posedge clk_sys) disable iff (rst) ($fell(ras_n_reg) && !cas_n_reg) |-> !$past(cas_n_reg) ##1 !cas_n_reg;
	endproperty
	a_cbr_order: assert property (p_cbr_order) else $error("column-first setup or hold broken"); // RULE_16

	property p_read_end;
		@(posedge clk_sys) disable iff (rst) ($rose(cas_n_reg) && !$past(oe_n_reg)) |-> $past(we_n_reg) && we_n_reg;
	endproperty
	a_read_end: assert property (p_read_end) else $error("write strobe active at end of read"); // RULE_08

	property p_hpc;
		@(posedge clk_sys) disable iff (rst) $fell(cas_n_reg) |-> ##1 !$fell(cas_n_reg) ##1 !$fell(cas_n_reg);
	endproperty
	a_hpc: assert property (p_hpc) else $error("column cycle shorter than the page minimum"); // RULE_12

	property p_rhcp;
		@(posedge clk_sys) disable iff (rst) ($rose(cas_n_reg) && !ras_n_reg) |=> !ras_n_reg;
	endproperty
	a_rhcp: assert property (p_rhcp) else $error("row strobe rose too soon after column precharge"); // RULE_19

	property p_sr_exit;
		@(posedge clk_sys) disable iff (rst) ($rose(ras_n_reg) && sr_reg) |-> ras_low_reg >= CNT_W'(RASS_CYCLES) ##1 ras_n_reg [*5];
	endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("self-refresh low or exit time too short"); // RULE_17

	property p_ref_deadline;
		@(posedge clk_sys) disable iff (rst) since_ref_reg < CNT_W'(REF_INTERVAL + RASP_CYCLES + 64);
	endproperty
	a_ref_deadline: assert property (p_ref_deadline) else $error("refresh overdue"); // RULE_20

	property p_early_write;
		@(posedge clk_sys) disable iff (rst) $fell(cas_n_reg) && !we_n_reg |-> !$past(we_n_reg) && oe_n_reg && dq_oe_reg;
	endproperty
	a_early_write: assert property (p_early_write) else $error("write not set up as an early write"); // RULE_06

	c_read: cover property (@(posedge clk_sys) disable iff (rst) rsp_valid_reg);
	c_page_hit: cover property (@(posedge clk_sys) disable iff (rst) (state_reg == ST_CAS_HI) && page_hit);
	c_refresh: cover property (@(posedge clk_sys) disable iff (rst) init_done_reg && cbr_fall && !sr_reg);
	c_sleep_exit: cover property (@(posedge clk_sys) disable iff (rst) $fell(sr_reg));

endmodule : edc_ctrl

// >>> tb/edc_dram_model.sv
`timescale 1ns/1ns
module edc_dram_model #(
	parameter int ROW_W = 12,
	parameter int COL_W = 10,
	parameter int DQ_W = 4
) (
	input wire logic ras_n, // Row strobe.
	input wire logic cas_n, // Column strobe.
	input wire logic we_n, // Write strobe.
	input wire logic oe_n, // Output gate.
	input wire logic [ROW_W-1:0] addr, // Multiplexed address.
	input wire logic [DQ_W-1:0] dq, // Resolved data wire.
	output logic [DQ_W-1:0] q, // Data driven by the memory.
	output logic q_en, // High while the memory drives.
	output logic [15:0] cbr_count, // Column-first refreshes seen.
	output logic early_access // Access seen before warm-up ended.
);
	logic [DQ_W-1:0] mem [int];
	logic [ROW_W-1:0] row_reg;
	logic rd_cyc;
	int key;
	initial begin
		q = '0;
		rd_cyc = 1'b0;
		row_reg = '0;
		cbr_count = '0;
		early_access = 1'b0;
	end
	// Turn-off is immediate, which is the harshest case inside the allowed window.
	assign q_en = rd_cyc && !oe_n && we_n && !(ras_n && cas_n);
	// Strobe edges are looked at just after they occur, since the controller may move the address in the same step.
	always @(negedge ras_n) begin
		#1;
		if (cas_n === 1'b0)
			cbr_count <= cbr_count + 16'h1;
		else
			row_reg <= addr;
	end
	always @(negedge cas_n) begin
		#1;
		if (ras_n === 1'b0) begin
			key = int'({row_reg, addr[COL_W-1:0]});
			if (cbr_count < 16'h8)
				early_access <= 1'b1;
			if (we_n === 1'b0) begin
				mem[key] = dq;
				rd_cyc = 1'b0;
			end else begin
				rd_cyc = 1'b1;
				// Old data is kept only for the hold time, then garbage until the new access completes.
				q <= #5 ~q;
				q <= #15 mem.exists(key) ? mem[key] : ~dq;
			end
		end
	end
	always @(posedge ras_n or posedge cas_n) begin
		if (ras_n && cas_n)
			rd_cyc = 1'b0;
	end
	// A write strobe falling inside a read makes it a read-write cycle; the old data was already shown.
	always @(negedge we_n) begin
		if (ras_n === 1'b0 && cas_n === 1'b0 && rd_cyc) begin
			mem[key] = dq;
			rd_cyc = 1'b0;
		end
	end
endmodule : edc_dram_model

// >>> tb/test_edo_dram_access_refresh_timing.sv
`timescale 1ns/1ns
module test_edo_dram_access_refresh_timing import edc_pkg::*;;
	localparam int PWR = 20;
	localparam int RASS = 20;
	localparam int RASP = 64;
	localparam int REF = 100;
	logic clk_sys, rst, req_valid, req_write, sleep_req, req_ack, rsp_valid, init_done, sleeping;
	logic ras_n, cas_n, we_n, oe_n, dq_oe, q_en, early_access, clash, csr_bad, ras_q, cas_q;
	logic [21:0] req_addr;
	logic [11:0] d_addr;
	logic [3:0] req_wdata, rsp_rdata, dq_out, dq_in, q, last_dq;
	logic [15:0] cbr_count;
	int miscompares, cmp_count, cyc, ras_lo, max_lo;
	int aq[$];
	int lat_q[$];
	logic [3:0] dat_q[$];
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// A released data wire shows the inverse of its last value so that a stale sample cannot match.
	assign dq_in = dq_oe ? dq_out : (q_en ? q : ~last_dq);
	always @(dq_oe, q_en, dq_out, q) begin
		if (dq_oe)
			last_dq = dq_out;
		else if (q_en)
			last_dq = q;
	end
	edc_ctrl #(.PWRUP_CYCLES(PWR), .RASP_CYCLES(RASP), .RASS_CYCLES(RASS), .REF_INTERVAL(REF)) edc_ctrl_i (
		.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .sleep_req(sleep_req), .req_ack(req_ack), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .init_done(init_done), .sleeping(sleeping), .dram_ras_n(ras_n),
		.dram_cas_n(cas_n), .dram_we_n(we_n), .dram_oe_n(oe_n), .dram_addr(d_addr), .dram_dq_in(dq_in),
		.dram_dq_out(dq_out), .dram_dq_oe(dq_oe));
	edc_dram_model edc_dram_model_i (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(d_addr),
		.dq(dq_in), .q(q), .q_en(q_en), .cbr_count(cbr_count), .early_access(early_access));
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		ras_q <= ras_n;
		cas_q <= cas_n;
		ras_lo <= ras_n ? 0 : ras_lo + 1;
		if (dq_oe && q_en)
			clash <= 1'b1;
		if (ras_q && !ras_n && !cas_n && cas_q)
			csr_bad <= 1'b1;
		if (!ras_n && !sleeping && ras_lo >= max_lo)
			max_lo <= ras_lo + 1;
		if (rsp_valid && aq.size() > 0) begin
			lat_q.push_back(cyc - aq.pop_front());
			dat_q.push_back(rsp_rdata);
		end
		if (req_ack && !req_write)
			aq.push_back(cyc);
		if (cyc == 5000) begin
			miscompares++;
			report_and_stop;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic send(input logic wr, input logic [21:0] a, input logic [3:0] d);
		int n;
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_wdata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ack !== 1'b1 && n < 500);
		check(req_ack, 1);
	endtask : send
	task automatic idle;
		req_valid <= 1'b0;
		@(posedge clk_sys);
	endtask : idle
	task automatic expect_rd(input logic [3:0] exp, input int lat);
		int n;
		n = 0;
		while (dat_q.size() == 0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		check(dat_q.size() > 0, 1);
		if (dat_q.size() > 0) begin
			check(dat_q.pop_front(), exp);
			n = lat_q.pop_front();
			if (lat > 0)
				check(n, lat);
		end
	endtask : expect_rd
	task automatic t_init;
		send(1'b1, {12'h001, 10'h005}, 4'ha);
		check(init_done, 1);
		check(cyc >= PWR + 5, 1);
		check(cbr_count, 8);
		check(early_access, 0);
	endtask : t_init
	task automatic t_rw;
		send(1'b1, {12'h002, 10'h3ff}, 4'h5);
		send(1'b1, {12'h0a5, 10'h001}, 4'h6);
		send(1'b1, {12'h0a5, 10'h002}, 4'h9);
		idle;
		repeat (10) @(posedge clk_sys);
		send(1'b0, {12'h001, 10'h005}, 4'h0);
		send(1'b0, {12'h002, 10'h3ff}, 4'h0);
		idle;
		expect_rd(4'ha, 5);
		expect_rd(4'h5, -1);
		check(clash, 0);
	endtask : t_rw
	task automatic t_refresh;
		int n, k0;
		n = 0;
		k0 = cbr_count;
		while (cbr_count == k0 && n < 150) begin
			@(posedge clk_sys);
			n++;
		end
		k0 = cbr_count;
		repeat (9 * REF + REF / 2) @(posedge clk_sys);
		check(cbr_count - k0, 9);
	endtask : t_refresh
	task automatic t_page;
		send(1'b0, {12'h0a5, 10'h001}, 4'h0);
		send(1'b0, {12'h0a5, 10'h002}, 4'h0);
		idle;
		expect_rd(4'h6, 5);
		expect_rd(4'h9, 4);
	endtask : t_page
	task automatic t_burst;
		int c0, k0, i;
		c0 = cyc;
		k0 = cbr_count;
		max_lo = 0;
		for (i = 0; i < 80; i++)
			send(1'b0, {12'h0a5, 8'h00, i[0], ~i[0]}, 4'h0);
		idle;
		for (i = 0; i < 80; i++)
			expect_rd(i[0] ? 4'h9 : 4'h6, -1);
		check(cbr_count - k0 >= (cyc - c0) / REF - 1, 1);
		check(max_lo <= RASP, 1);
	endtask : t_burst
	task automatic t_sleep;
		int n;
		sleep_req <= 1'b1;
		n = 0;
		while (!(sleeping === 1'b1 && ras_n === 1'b0) && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		// Dropping the request at once shows whether the minimum low time is honoured on its own.
		sleep_req <= 1'b0;
		n = 0;
		while (ras_n === 1'b0 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		check(n >= RASS, 1);
		n = 0;
		while (ras_n === 1'b1 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		check(n >= RPS_CYC, 1);
		check(sleeping, 0);
		send(1'b0, {12'h001, 10'h005}, 4'h0);
		idle;
		expect_rd(4'ha, 5);
		check(csr_bad, 0);
	endtask : t_sleep
	task automatic report_and_stop;
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		sleep_req = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		cyc = 0;
		ras_lo = 0;
		max_lo = 0;
		clash = 1'b0;
		csr_bad = 1'b0;
		last_dq = '0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_init;
		t_rw;
		t_refresh;
		t_page;
		t_burst;
		t_sleep;
		report_and_stop;
	end
endmodule : test_edo_dram_access_refresh_timing
